// [src/pmws_seq.sv]
// Behaviour
// - decode select pins: serial or eight presets
// - clock output is time base divided by 4 (800 kHz at 3200 kHz)
// - clock output starts 80 us after time base
// - preset idle 2^14 ticks forces shutdown
// - data high clears idle counter, end shuts
// - data pulse in preset shutdown starts warm-up
// - default amplifier drive duty is 25%
// - boost bit raises duty to 50%
// - five-bit tuning cap field at 0x07
// - preset mode forces tuning cap zero
// - three-bit drive level sets driver count
// - preset mode forces drive level 0x7
// - crystal starts on wake or address match
// - divider code picks ratio 4, 5, 6
`include "pmws_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module pmws_seq #(
   parameter int IDLE_TICKS = `PMWS_IDLE_TICKS,
   parameter int BUFFERED_DIVIDED_CLOCK_OUT_DLY = `PMWS_BUFFERED_DIVIDED_CLOCK_OUT_DLY_TICKS
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // three-state select pins, detector levels
   input wire logic [1:0] mode_select_hi,
   input wire logic [1:0] mode_select_lo,
   // data pin
   input wire logic data_pin,
   // crystal edge strobe, one per crystal cycle
   input wire logic xtal_tick,
   // serial interface register port
   input wire logic bus_addr_match,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // mode decode
   output logic serial_mode,
   output logic [2:0] preset_sel,
   // power control
   output logic xo_enable,
   output logic synth_enable,
   output logic shutdown,
   output logic buffered_divided_clock_out,
   // amplifier control
   output logic [2:0] amp_drive_level,
   output logic [4:0] amp_tune_cap_code,
   output logic amp_duty_boost,
   // transmit bit stream
   output logic tx_bit_valid,
   output logic tx_bit,
   input wire logic tx_bit_ready
);

   initial begin
      if (IDLE_TICKS < 2) $error("pmws_seq: IDLE_TICKS too small");
      if (BUFFERED_DIVIDED_CLOCK_OUT_DLY < 1) $error("pmws_seq: BUFFERED_DIVIDED_CLOCK_OUT_DLY too small");
   end

   localparam int IW = $clog2(IDLE_TICKS + 1); // idle counter width
   localparam int DW = $clog2(BUFFERED_DIVIDED_CLOCK_OUT_DLY + 1); // start delay width
   localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_TICKS - 1);
   localparam logic [DW-1:0] DLY_LAST = DW'(BUFFERED_DIVIDED_CLOCK_OUT_DLY - 1);
   localparam logic [1:0] HALF_LAST = 2'(`PMWS_BUFFERED_DIVIDED_CLOCK_OUT_HALF_TICKS - 1);

   // synchronised pins
   logic [4:0] pins_sync; // select levels and data
   logic [1:0] sel_hi; // upper select level
   logic [1:0] sel_lo; // lower select level
   logic data_s; // data pin level

   pmws_sync2 #(
      .W(5)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin_in({mode_select_hi, mode_select_lo, data_pin}),
      .sync_out(pins_sync)
   );

   assign sel_hi = pins_sync[4:3];
   assign sel_lo = pins_sync[2:1];
   assign data_s = pins_sync[0];

   // mode decode
   logic [1:0] hi_n; // level as 0..2, unknown taken as open
   logic [1:0] lo_n;
   logic [3:0] combo; // 3*hi + lo
   logic is_serial; // both grounded

   assign hi_n = (sel_hi == `PMWS_LVL_VDD) ? 2'h2 : ((sel_hi == `PMWS_LVL_GND) ? 2'h0 : 2'h1);
   assign lo_n = (sel_lo == `PMWS_LVL_VDD) ? 2'h2 : ((sel_lo == `PMWS_LVL_GND) ? 2'h0 : 2'h1);
   assign combo = {1'b0, hi_n, 1'b0} + {2'h0, hi_n} + {2'h0, lo_n};
   assign is_serial = (combo == 4'h0);

   // registered mode outputs
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         serial_mode <= 1'b1;
         preset_sel <= 3'h0;
      end else begin
         serial_mode <= is_serial;
         // preset 0..7 in table order
         preset_sel <= is_serial ? 3'h0 : 3'(combo - 4'h1);
      end
   end

   // software registers
   logic [7:0] cfg_ff; // divider code
   logic [7:0] shutdown_and_boost_ctrl_ff; // boost bit
   logic [7:0] pwr_ff; // drive level
   logic [7:0] cap_ff; // tuning cap

   // writes only land in serial mode
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cfg_ff <= `PMWS_CFG_RST;
         shutdown_and_boost_ctrl_ff <= `PMWS_SHUTDOWN_AND_BOOST_CTRL_RST;
         pwr_ff <= `PMWS_PWR_RST;
         cap_ff <= `PMWS_CAP_RST;
      end else if (reg_wr && serial_mode) begin
         case (reg_addr)
            `PMWS_OFS_CFG: begin
               cfg_ff <= reg_wdata;
            end
            `PMWS_OFS_SHUTDOWN_AND_BOOST_CTRL_BOOST: begin
               shutdown_and_boost_ctrl_ff <= reg_wdata;
            end
            `PMWS_OFS_AMP_PWR: begin
               pwr_ff <= reg_wdata;
            end
            `PMWS_OFS_TUNE_CAP: begin
               cap_ff <= reg_wdata;
            end
            default: begin
               // unmapped writes are dropped
            end
         endcase
      end
   end

   // sequencer state
   pmws_pkg::pmws_state_t state_ff;
   logic tb_tick_ff; // one pulse per time-base cycle
   logic idle_end; // idle count expired

   // read data, one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `PMWS_OFS_CFG: begin
               reg_rdata <= cfg_ff;
            end
            `PMWS_OFS_SHUTDOWN_AND_BOOST_CTRL_BOOST: begin
               // top bit shows the running state
               reg_rdata <= {state_ff == pmws_pkg::PMWS_RUN, shutdown_and_boost_ctrl_ff[6:0]};
            end
            `PMWS_OFS_AMP_PWR: begin
               reg_rdata <= pwr_ff;
            end
            `PMWS_OFS_TUNE_CAP: begin
               reg_rdata <= cap_ff;
            end
            default: begin
               reg_rdata <= 8'h00;
            end
         endcase
      end
   end

   // amplifier controls, presets force their values
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         amp_drive_level <= 3'h0;
         amp_tune_cap_code <= 5'h00;
         amp_duty_boost <= 1'b0;
      end else if (!serial_mode) begin
         amp_drive_level <= `PMWS_PRESET_PWR;
         amp_tune_cap_code <= `PMWS_PRESET_CAP;
         amp_duty_boost <= 1'b0;
      end else begin
         amp_drive_level <= pwr_ff[`PMWS_PWR_MSB:0];
         amp_tune_cap_code <= cap_ff[`PMWS_CAP_MSB:0];
         // low gives 25% drive, high gives 50%
         amp_duty_boost <= shutdown_and_boost_ctrl_ff[`PMWS_BOOST_BIT];
      end
   end

   // crystal divider to the time base
   logic [2:0] div_cnt_ff; // crystal cycles in this tick
   logic [1:0] div_code; // effective code
   logic [2:0] div_last; // ratio minus one

   assign div_code = serial_mode ? cfg_ff[`PMWS_DIV_MSB:`PMWS_DIV_LSB] : `PMWS_PRESET_DIV;
   // code 11 is not a ratio, held at 6
   assign div_last = (div_code == 2'h3) ? 3'h5 : 3'(`PMWS_DIV_BASE + {1'b0, div_code} - 3'h1);

   always_ff @(posedge clk_sys) begin
      if (reset || !xo_enable) begin
         div_cnt_ff <= 3'h0;
         tb_tick_ff <= 1'b0;
      end else if (xtal_tick) begin
         tb_tick_ff <= (div_cnt_ff >= div_last);
         div_cnt_ff <= (div_cnt_ff >= div_last) ? 3'h0 : 3'(div_cnt_ff + 3'h1);
      end else begin
         tb_tick_ff <= 1'b0;
      end
   end

   // idle counter, preset mode only
   logic [IW-1:0] idle_ff;
   assign idle_end = tb_tick_ff && (idle_ff == IDLE_LAST) && !data_s;

   always_ff @(posedge clk_sys) begin
      if (reset || serial_mode || state_ff != pmws_pkg::PMWS_RUN) begin
         idle_ff <= '0;
      end else if (data_s) begin
         idle_ff <= '0;
      end else if (tb_tick_ff) begin
         idle_ff <= IW'(idle_ff + 1'b1);
      end
   end

   // power sequencing
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_ff <= pmws_pkg::PMWS_SHUTDOWN;
      end else begin
         case (state_ff)
            pmws_pkg::PMWS_SHUTDOWN: begin
               // wake on data in preset, address in serial
               if ((!serial_mode && data_s) || (serial_mode && bus_addr_match)) begin
                  state_ff <= pmws_pkg::PMWS_WARMUP;
               end
            end
            pmws_pkg::PMWS_WARMUP: begin
               // first divider tick marks the time base ready
               if (tb_tick_ff) begin
                  state_ff <= pmws_pkg::PMWS_RUN;
               end
            end
            pmws_pkg::PMWS_RUN: begin
               if (idle_end) begin
                  state_ff <= pmws_pkg::PMWS_SHUTDOWN;
               end
            end
            default: begin
               state_ff <= pmws_pkg::PMWS_SHUTDOWN;
            end
         endcase
      end
   end

   // power outputs follow the state
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         xo_enable <= 1'b0;
         synth_enable <= 1'b0;
         shutdown <= 1'b1;
      end else begin
         xo_enable <= (state_ff != pmws_pkg::PMWS_SHUTDOWN) && !idle_end;
         synth_enable <= (state_ff != pmws_pkg::PMWS_SHUTDOWN) && !idle_end;
         shutdown <= (state_ff == pmws_pkg::PMWS_SHUTDOWN) || idle_end;
      end
   end

   // clock output start delay and divider
   logic [DW-1:0] dly_ff; // ticks since time base ready
   logic dly_done_ff; // delay elapsed
   logic [1:0] half_ff; // ticks in this half period

   always_ff @(posedge clk_sys) begin
      if (reset || state_ff != pmws_pkg::PMWS_RUN) begin
         dly_ff <= '0;
         dly_done_ff <= 1'b0;
      end else if (tb_tick_ff && !dly_done_ff) begin
         dly_ff <= DW'(dly_ff + 1'b1);
         dly_done_ff <= (dly_ff == DLY_LAST);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset || !dly_done_ff) begin
         half_ff <= 2'h0;
         buffered_divided_clock_out <= 1'b0;
      end else if (tb_tick_ff) begin
         // fixed ratio, independent of preset
         if (half_ff == HALF_LAST) begin
            half_ff <= 2'h0;
            buffered_divided_clock_out <= !buffered_divided_clock_out;
         end else begin
            half_ff <= 2'(half_ff + 2'h1);
         end
      end
   end

   // data sampling into the transmit buffer
   logic smp_valid; // sample offered this cycle, dropped while the buffer is full

   // one sample per time-base tick while running in preset
   assign smp_valid = tb_tick_ff && !serial_mode && (state_ff == pmws_pkg::PMWS_RUN);

   pmws_buf2 #(
      .W(1)
   ) u_buf (
      .clk_sys(clk_sys),
      .reset(reset),
      .in_valid(smp_valid),
      .in_data(data_s),
      .in_ready(),
      .out_valid(tx_bit_valid),
      .out_data(tx_bit),
      .out_ready(tx_bit_ready)
   );

endmodule

`default_nettype wire

// [common/pmws_defs.svh]
`ifndef PMWS_DEFS_SVH
`define PMWS_DEFS_SVH

// register offsets
`define PMWS_OFS_CFG 8'h00
`define PMWS_OFS_SHUTDOWN_AND_BOOST_CTRL_BOOST 8'h05
`define PMWS_OFS_AMP_PWR 8'h06
`define PMWS_OFS_TUNE_CAP 8'h07

// field positions
`define PMWS_DIV_LSB 4
`define PMWS_DIV_MSB 5
`define PMWS_BOOST_BIT 0
`define PMWS_RUN_BIT 7
`define PMWS_PWR_MSB 2
`define PMWS_CAP_MSB 4

// reset values
`define PMWS_CFG_RST 8'h10
`define PMWS_SHUTDOWN_AND_BOOST_CTRL_RST 8'h00
`define PMWS_PWR_RST 8'h00
`define PMWS_CAP_RST 8'h00

// forced preset values and divider base
`define PMWS_PRESET_DIV 2'h1
`define PMWS_PRESET_PWR 3'h7
`define PMWS_PRESET_CAP 5'h00
`define PMWS_DIV_BASE 3'h4

// pin levels from the three-state detector
`define PMWS_LVL_GND 2'h0
`define PMWS_LVL_OPEN 2'h1
`define PMWS_LVL_VDD 2'h2

// timing, in kHz, us and time-base ticks
`define PMWS_TB_KHZ 3200
`define PMWS_BUFFERED_DIVIDED_CLOCK_OUT_KHZ 800
`define PMWS_BUFFERED_DIVIDED_CLOCK_OUT_DLY_US 80
`define PMWS_BUFFERED_DIVIDED_CLOCK_OUT_DLY_TICKS ((`PMWS_BUFFERED_DIVIDED_CLOCK_OUT_DLY_US * `PMWS_TB_KHZ + 999) / 1000)
`define PMWS_BUFFERED_DIVIDED_CLOCK_OUT_HALF_TICKS (`PMWS_TB_KHZ / `PMWS_BUFFERED_DIVIDED_CLOCK_OUT_KHZ / 2)
`define PMWS_IDLE_TICKS 16384

`endif

// [common/pmws_pkg.sv]
package pmws_pkg;

   // power sequencing states
   typedef enum logic [1:0] {
      PMWS_SHUTDOWN,
      PMWS_WARMUP,
      PMWS_RUN
   } pmws_state_t;

endpackage

// [src/pmws_sync2.sv]
`timescale 1ns/1ns
`default_nettype none

// two-flop synchroniser for pin levels
module pmws_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // pin side
   input wire logic [W-1:0] pin_in,
   // synchronised side
   output logic [W-1:0] sync_out
);

   initial begin
      if (W < 1) $error("pmws_sync2: W must be at least 1");
   end

   logic [W-1:0] meta_ff; // first stage, read only by second

   // both stages clear on reset
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         meta_ff <= '0;
         sync_out <= '0;
      end else begin
         meta_ff <= pin_in;
         sync_out <= meta_ff;
      end
   end

endmodule

`default_nettype wire

// [src/pmws_buf2.sv]
`timescale 1ns/1ns
`default_nettype none

// two-entry buffer, all outputs registered
module pmws_buf2 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // fill side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // drain side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);

   initial begin
      if (W < 1) $error("pmws_buf2: W must be at least 1");
   end

   logic [W-1:0] spare_ff; // second entry
   logic spare_vld_ff; // second entry holds a word
   logic push; // word taken this cycle
   logic pop; // word leaves this cycle

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // head and spare entries
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         out_valid <= 1'b0;
         spare_vld_ff <= 1'b0;
         out_data <= '0;
         spare_ff <= '0;
      end else if (pop) begin
         // head leaves, spare or new word moves up
         out_valid <= spare_vld_ff | push;
         out_data <= spare_vld_ff ? spare_ff : in_data;
         spare_vld_ff <= 1'b0;
      end else if (push) begin
         // fill head first, then spare
         if (!out_valid) begin
            out_valid <= 1'b1;
            out_data <= in_data;
         end else begin
            spare_vld_ff <= 1'b1;
            spare_ff <= in_data;
         end
      end
   end

   // ready is low in reset and while both entries are full
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         in_ready <= 1'b0;
      end else begin
         in_ready <= !((out_valid & !pop & (push | spare_vld_ff))
            | (spare_vld_ff & !pop));
      end
   end

endmodule

`default_nettype wire

// [sim/pmws_seq_assertions.sv]
`timescale 1ns/1ns
`default_nettype none

// pin-level checks on the power sequencer
module pmws_seq_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // register port
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   // mode and power
   input wire logic serial_mode,
   input wire logic [2:0] preset_sel,
   input wire logic xo_enable,
   input wire logic synth_enable,
   input wire logic shutdown,
   // amplifier
   input wire logic [2:0] amp_drive_level,
   input wire logic [4:0] amp_tune_cap_code,
   input wire logic amp_duty_boost,
   // bit stream
   input wire logic tx_bit_valid,
   input wire logic tx_bit,
   input wire logic tx_bit_ready,
   // data pin
   input wire logic data_pin
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   // preset forces amplifier settings
   chk_preset_drive: assert property (!serial_mode && !$past(serial_mode) |-> amp_drive_level == 3'h7)
      else $error("drive level not forced in preset");
   chk_preset_cap: assert property (!serial_mode && !$past(serial_mode) |-> amp_tune_cap_code == 5'h00)
      else $error("tuning cap not forced in preset");
   chk_preset_boost: assert property (!serial_mode && !$past(serial_mode) |-> !amp_duty_boost)
      else $error("boost set in preset");
   // register writes reach the amplifier two edges later
   chk_cap_write: assert property (serial_mode && reg_wr && reg_addr == 8'h07 |->
      ##2 {3'h0, amp_tune_cap_code} == ($past(reg_wdata, 2) & 8'h1F))
      else $error("tuning cap write lost");
   chk_drive_write: assert property (serial_mode && reg_wr && reg_addr == 8'h06 |->
      ##2 {5'h00, amp_drive_level} == ($past(reg_wdata, 2) & 8'h07))
      else $error("drive level write lost");
   // crystal and synthesizer move together, opposite shutdown
   chk_xo_pair: assert property (xo_enable == synth_enable && shutdown != xo_enable)
      else $error("power levels disagree");
   // a data pulse in preset shutdown starts the crystal: two sync flops, state, output
   chk_wake_start: assert property ((!serial_mode && shutdown && data_pin) [*3] |-> ##[1:3] xo_enable)
      else $error("no crystal start after data pulse");
   // serial mode reports no preset and never idles out
   chk_serial_sel: assert property (serial_mode |-> preset_sel == 3'h0)
      else $error("preset index in serial mode");
   chk_serial_noshut: assert property (serial_mode && $past(serial_mode) && !shutdown |=> !shutdown)
      else $error("shutdown in serial mode");
   // a stalled bit stays put
   chk_tx_hold: assert property (tx_bit_valid && !tx_bit_ready |=> tx_bit_valid && $stable(tx_bit))
      else $error("stalled bit changed");

   // main scenarios
   cov_wake: cover property ($rose(xo_enable) && !serial_mode);
   cov_shut: cover property ($rose(shutdown) && !serial_mode);
   cov_stall: cover property (tx_bit_valid && !tx_bit_ready);
endmodule

`default_nettype wire

// [sim/pmws_mcu_model.sv]
`timescale 1ns/1ns
`default_nettype none

// controller side: drives the data pin push-pull
module pmws_mcu_model (
   // clock
   input wire logic clk_sys,
   // data pin
   output logic data_pin
);
   // 10 us at 20 MHz before the first data bit
   localparam int TX_WAIT = 200;

   initial data_pin = 1'b0;

   // wake pulse outlasting crystal and synth warm-up
   task automatic wake(input int len);
      @(negedge clk_sys) data_pin = 1'b1;
      repeat (len) @(negedge clk_sys);
      data_pin = 1'b0;
      repeat (TX_WAIT) @(negedge clk_sys);
   endtask

   // hold a level for a number of cycles
   task automatic drive(input logic b, input int len);
      data_pin = b;
      repeat (len) @(negedge clk_sys);
   endtask
endmodule

`default_nettype wire

// [sim/test_pmws_seq.sv]
`timescale 1ns/1ns
`default_nettype none

// bench for the power sequencer
module test_pmws_seq;
   localparam int IDLE = 32; // shortened idle count
   localparam int TB = 10; // clocks per tick: strobe every 2, ratio 5
   logic clk_sys = 1'b0, reset = 1'b1, xtal_tick = 1'b0, bus_addr_match = 1'b0;
   logic [1:0] mode_select_hi = 2'h0, mode_select_lo = 2'h0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, tx_bit_ready = 1'b1, data_pin;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic serial_mode, xo_enable, synth_enable, shutdown, clk_out, amp_duty_boost;
   logic tx_bit_valid, tx_bit;
   logic [2:0] preset_sel, amp_drive_level;
   logic [4:0] amp_tune_cap_code;
   int error_cnt = 0, n_tests = 0, cyc = 0, ones = 0, c;

   pmws_seq #(.IDLE_TICKS(IDLE), .BUFFERED_DIVIDED_CLOCK_OUT_DLY(4)) u_dut (
      .clk_sys(clk_sys), .reset(reset), .mode_select_hi(mode_select_hi),
      .mode_select_lo(mode_select_lo), .data_pin(data_pin), .xtal_tick(xtal_tick),
      .bus_addr_match(bus_addr_match), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_mode(serial_mode),
      .preset_sel(preset_sel), .xo_enable(xo_enable), .synth_enable(synth_enable),
      .shutdown(shutdown), .buffered_divided_clock_out(clk_out),
      .amp_drive_level(amp_drive_level), .amp_tune_cap_code(amp_tune_cap_code),
      .amp_duty_boost(amp_duty_boost), .tx_bit_valid(tx_bit_valid), .tx_bit(tx_bit),
      .tx_bit_ready(tx_bit_ready));
   pmws_mcu_model u_mcu (.clk_sys(clk_sys), .data_pin(data_pin));

   always #25 clk_sys = ~clk_sys;

   // crystal strobe every other cycle, hang guard
   always @(negedge clk_sys) begin
      xtal_tick <= ~xtal_tick;
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         error_cnt++;
         finish_test();
      end
   end

   // count accepted one bits
   always @(posedge clk_sys) begin
      if (tx_bit_valid === 1'b1 && tx_bit_ready === 1'b1 && tx_bit === 1'b1) begin
         ones <= ones + 1;
      end
   end

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      cmp(reg_rdata, exp);
   endtask

   // pick a watched output
   function automatic logic sig(input int k);
      case (k)
         0: return xo_enable;
         1: return shutdown;
         default: return clk_out;
      endcase
   endfunction

   // bounded wait for a level, cycles counted in n
   task automatic wt(input int k, input logic v, output int n);
      n = 0;
      while (sig(k) !== v && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
   endtask

   task automatic finish_test();
      $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(negedge clk_sys);
      reset = 1'b0;
      repeat (4) @(negedge clk_sys);
      // reset values
      cmp(shutdown, 1);
      cmp(amp_duty_boost, 0);
      rd(8'h00, 8'h10);
      rd(8'h07, 8'h00);
      rd(8'h33, 8'h00);
      $display("test reset done");
      // serial programming and address wake
      wr(8'h06, 8'h05);
      wr(8'h07, 8'h1F);
      wr(8'h05, 8'h01);
      wr(8'h40, 8'hFF);
      @(negedge clk_sys);
      cmp(amp_drive_level, 5);
      cmp(amp_tune_cap_code, 8'h1F);
      cmp(amp_duty_boost, 1);
      rd(8'h40, 8'h00);
      bus_addr_match = 1'b1;
      @(negedge clk_sys);
      bus_addr_match = 1'b0;
      wt(0, 1, c);
      cmp(c < 10, 1);
      repeat (2 * IDLE * TB) @(negedge clk_sys);
      cmp(shutdown, 0);
      rd(8'h05, 8'h81);
      // divider ratios 4 and 6, seen as a full low half of the clock out
      wr(8'h00, 8'h00);
      wt(2, 1, c);
      wt(2, 0, c);
      wt(2, 1, c);
      cmp(8'(c), 8'(2 * 8));
      wr(8'h00, 8'h20);
      wt(2, 1, c);
      wt(2, 0, c);
      wt(2, 1, c);
      cmp(8'(c), 8'(2 * 12));
      $display("test serial done");
      // select decode over all pin levels
      for (int i = 0; i < 3; i++) begin
         for (int j = 0; j < 3; j++) begin
            mode_select_hi = 2'(i);
            mode_select_lo = 2'(j);
            repeat (5) @(negedge clk_sys);
            cmp(serial_mode, 8'(i == 0 && j == 0));
            cmp(preset_sel, (i == 0 && j == 0) ? 8'h00 : 8'(i * 3 + j - 1));
         end
      end
      cmp(amp_drive_level, 7);
      wr(8'h07, 8'h0A);
      rd(8'h07, 8'h1F);
      cmp(amp_tune_cap_code, 0);
      cmp(amp_duty_boost, 0);
      wt(1, 1, c);
      cmp(c < IDLE * TB + 20, 1);
      $display("test preset done");
      // wake from shutdown, clock out start and rate
      fork
         u_mcu.wake(40);
         begin
            wt(0, 1, c);
            cmp(c < 10, 1);
            wt(2, 1, c);
            cmp(c >= 4 * TB && c <= 8 * TB, 1);
            wt(2, 0, c);
            cmp(8'(c), 8'(2 * TB));
         end
      join
      // bit stream, then a stall
      ones = 0;
      u_mcu.drive(1, 4 * TB);
      u_mcu.drive(0, 3 * TB);
      cmp(8'(ones), 4);
      tx_bit_ready = 1'b0;
      u_mcu.drive(0, 3 * TB);
      cmp(tx_bit_valid, 1);
      u_mcu.drive(1, 2 * TB);
      // let the synchronised high level pass before the drain restarts
      u_mcu.drive(0, TB);
      tx_bit_ready = 1'b1;
      u_mcu.drive(0, TB);
      cmp(8'(ones), 4);
      // high levels restart the idle count
      repeat (3) begin
         u_mcu.drive(1, TB);
         u_mcu.drive(0, (IDLE - 8) * TB);
         cmp(shutdown, 0);
      end
      u_mcu.drive(1, TB);
      u_mcu.drive(0, 1);
      wt(1, 1, c);
      cmp(c >= IDLE * TB - 15 && c <= IDLE * TB + 15, 1);
      $display("test wake done");
      finish_test();
   end
endmodule

bind pmws_seq pmws_seq_chk u_chk (.clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .serial_mode(serial_mode), .preset_sel(preset_sel),
   .xo_enable(xo_enable), .synth_enable(synth_enable), .shutdown(shutdown),
   .amp_drive_level(amp_drive_level), .amp_tune_cap_code(amp_tune_cap_code),
   .amp_duty_boost(amp_duty_boost), .tx_bit_valid(tx_bit_valid), .tx_bit(tx_bit),
   .tx_bit_ready(tx_bit_ready), .data_pin(data_pin));

`default_nettype wire
